/* design/csup_device.sv */
// Purpose: Charge supervisor: detection, start-up, default mode, timers, link slave
// Assumes: Analog comparators and pins arrive asynchronously
// Notes:   All intervals count microsecond and millisecond ticks
`timescale 1ns/100ps
// Notes on behaviour
// - Termination met starts battery detection
// - Sink held full interval means battery present
// - Voltage drop while sinking flags battery absent
// - Source after failed sink, then sink again
// - Repeat detection; found battery restarts charging
// - No detection while termination disabled
// - New supply gives one pulse, status
// - Charge inhibit bit blocks switch; clear starts
// - Charge starts 64 ms after soft-start
// - Gate drive when no supply, hi-Z, disable
// - Three causes enter default mode
// - Default entry reloads registers, restarts safety timer
// - Default regulation, charge current, input limit
// - Host write exits default; done stays done
// - Safety expiry stops charge, inhibits, pulses
// - Host clears inhibit to resume, clear fault
// - Duration field sets length; change resets
// - Slow timer halves rate when curtailed
// - Listed events reset the safety timer
// - First link access starts watchdog
// - Kick bit restarts watchdog, reads zero
// - Watchdog expiry enters default, keeps charging
// - Disable pin resets timer, forces hi-Z
module csup_device #(
	parameter int P_US_CYC    = csup_pkg::LP_US_CYC,
	parameter int P_US_PER_MS = csup_pkg::LP_US_PER_MS,
	parameter int P_START_MS  = csup_pkg::LP_START_MS,
	parameter int P_DETECT_MS = csup_pkg::LP_DETECT_MS,
	parameter int P_WDOG_MS   = csup_pkg::LP_WDOG_MS,
	parameter int P_SAFE_MS   = csup_pkg::LP_SAFE_MS
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	csup_link_if.device     link,
	input  wire logic       i_supply_valid,
	input  wire logic       i_chip_disable_pin,
	input  wire logic       i_vbat_above_detect,
	input  wire logic       i_vbat_low,
	input  wire logic       i_curtail,
	input  wire logic       i_thermal_shutdown,
	input  wire logic       i_battery_attached,
	input  wire logic       i_fault_active,
	input  wire logic       i_term_met,
	output logic            o_stat_pulse,
	output logic            o_discharge_gate_drive,
	output logic            o_detect_sink,
	output logic            o_detect_source,
	output logic            o_battery_switch_on,
	output logic            o_default_mode,
	output logic [7:0]      o_battery_regulation_level,
	output logic [7:0]      o_charge_current_setting,
	output logic [7:0]      o_input_limit
);
	logic       scl_s, sda_s, sup_s, cd_s, above_s, low_s, curt_s, therm_s, bat_s, flt_s, term_s;
	logic       scl_q, sda_q, cd_q, therm_q, bat_q, flt_q;
	logic [15:0] us_cnt, ms_cnt;
	logic       us_tick, ms_tick;
	logic [4:0] bit_cnt;
	logic [6:0] shift, addr_reg;
	logic [7:0] tx_reg, wdata_reg, rd_mux, ctrl_reg, safe_reg, limit_reg, vreg_reg, ichg_reg;
	logic       rw_reg, acc_ev, wr_ev, host_seen, supnew_reg, safe_flt, absent_reg, done_reg;
	logic       start_ev, safe_exp, wd_run, wd_exp, half_reg, stat_cnt_end;
	logic [31:0] st_cnt, safe_cnt, wd_cnt;
	logic [7:0] p_cnt;
	logic [3:0] cfg_q;
	csup_pkg::csup_state_e state;
	wire [7:0]  hdr       = {shift, sda_s};
	wire        inhibit   = ctrl_reg[csup_pkg::LP_CTRL_INH];
	wire        term_en   = ctrl_reg[csup_pkg::LP_CTRL_TERM];
	wire        hz_eff    = ctrl_reg[csup_pkg::LP_CTRL_HIZ] | cd_s;
	wire [1:0]  dur       = safe_reg[csup_pkg::LP_SAFE_DUR +: 2];
	wire        new_sup   = (state == csup_pkg::S_OFF) && sup_s && !hz_eff;
	wire        wr_ctrl   = wr_ev && addr_reg == csup_pkg::LP_REG_CTRL;
	wire        kick_ev   = wr_ctrl && wdata_reg[csup_pkg::LP_CTRL_KICK];
	wire        enter_def = (wd_exp && !safe_flt)
		| (!host_seen && !o_default_mode && !inhibit && low_s)
		| (!flt_s && flt_q && !host_seen);
	wire [3:0]  cfg_now   = {dur, inhibit, ctrl_reg[csup_pkg::LP_CTRL_HIZ]};
	wire        safe_rst  = enter_def | start_ev | (cfg_now != cfg_q)
		| (therm_s & !therm_q) | (bat_s ^ bat_q) | (cd_s & !cd_q);
	wire        slow_now  = safe_reg[csup_pkg::LP_SAFE_SLOW]
		& (curt_s | safe_reg[csup_pkg::LP_SAFE_LOW]);
	wire [31:0] safe_lim  = 32'(P_SAFE_MS) << dur;

	csup_sync #(.W(11)) u_sync (
		.i_clk (i_clk),
		.i_d   ({link.scl, link.sda, i_supply_valid, i_chip_disable_pin, i_vbat_above_detect,
			i_vbat_low, i_curtail, i_thermal_shutdown, i_battery_attached, i_fault_active,
			i_term_met}),
		.o_q   ({scl_s, sda_s, sup_s, cd_s, above_s, low_s, curt_s, therm_s, bat_s, flt_s,
			term_s})
	);

	assign link.sda_d_out             = 1'b0;
	assign o_battery_regulation_level = vreg_reg;
	assign o_charge_current_setting   = ichg_reg;
	assign o_input_limit              = limit_reg;

	// ----------------------------------------------------------------
	// Edge history and tick prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			{scl_q, sda_q, cd_q, therm_q, bat_q, flt_q} <= 6'h30;
			cfg_q <= 4'h0;
		end
		else
		begin
			{scl_q, sda_q, cd_q, therm_q, bat_q, flt_q} <= {scl_s, sda_s, cd_s, therm_s, bat_s, flt_s};
			cfg_q <= cfg_now;
		end

	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			us_cnt  <= 16'h0000;
			ms_cnt  <= 16'h0000;
			us_tick <= 1'b0;
			ms_tick <= 1'b0;
		end
		else
		begin
			us_tick <= us_cnt == 16'(P_US_CYC - 1);
			us_cnt  <= (us_cnt == 16'(P_US_CYC - 1)) ? 16'h0000 : us_cnt + 16'h0001;
			ms_tick <= us_tick && ms_cnt == 16'(P_US_PER_MS - 1);
			if (us_tick)
				ms_cnt <= (ms_cnt == 16'(P_US_PER_MS - 1)) ? 16'h0000 : ms_cnt + 16'h0001;
		end

	// ----------------------------------------------------------------
	// Link slave
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_mux = 8'h00;
		if (hdr[6:0] == csup_pkg::LP_REG_STATUS)
			rd_mux = {3'h0, o_default_mode, safe_flt, absent_reg, done_reg, supnew_reg};
		else if (hdr[6:0] == csup_pkg::LP_REG_LIMIT)
			rd_mux = limit_reg;
		else if (hdr[6:0] == csup_pkg::LP_REG_CTRL)
			rd_mux = ctrl_reg;
		else if (hdr[6:0] == csup_pkg::LP_REG_VREG)
			rd_mux = vreg_reg;
		else if (hdr[6:0] == csup_pkg::LP_REG_ICHG)
			rd_mux = ichg_reg;
		else if (hdr[6:0] == csup_pkg::LP_REG_SAFE)
			rd_mux = safe_reg;
	end

	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			bit_cnt         <= 5'h00;
			shift           <= 7'h00;
			link.sda_d_oe_n <= 1'b1;
			{rw_reg, addr_reg, tx_reg, wdata_reg} <= 24'h00_0000;
			acc_ev          <= 1'b0;
			wr_ev           <= 1'b0;
		end
		else
		begin
			acc_ev <= 1'b0;
			wr_ev  <= 1'b0;
			// Start or stop only ever happens with the line released by us
			if (scl_s && scl_q && sda_q != sda_s)
			begin
				bit_cnt         <= 5'h00;
				link.sda_d_oe_n <= 1'b1;
			end
			else if (scl_s && !scl_q && bit_cnt < csup_pkg::LP_FRAME_BITS)
			begin
				shift   <= hdr[6:0];
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == csup_pkg::LP_HDR_LAST)
				begin
					{rw_reg, addr_reg} <= hdr;
					tx_reg <= rd_mux;
					acc_ev <= 1'b1;
				end
				if (bit_cnt == csup_pkg::LP_FRAME_LAST && !rw_reg)
				begin
					wr_ev     <= 1'b1;
					wdata_reg <= hdr;
				end
			end
			else if (!scl_s && scl_q)
			begin
				if (rw_reg && bit_cnt >= csup_pkg::LP_DATA_FIRST && bit_cnt <= csup_pkg::LP_FRAME_LAST)
				begin
					link.sda_d_oe_n <= tx_reg[7];
					tx_reg          <= {tx_reg[6:0], 1'b0};
				end
				else
					link.sda_d_oe_n <= 1'b1;
			end
		end

	// ----------------------------------------------------------------
	// Register file and mode
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
		if (i_rst || enter_def)
		begin
			ctrl_reg  <= csup_pkg::LP_CTRL_DEF;
			safe_reg  <= csup_pkg::LP_SAFE_DEF;
			limit_reg <= csup_pkg::LP_LIMIT_DEF;
			vreg_reg  <= csup_pkg::LP_VREG_DEF;
			ichg_reg  <= csup_pkg::LP_ICHG_DEF;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= wdata_reg & csup_pkg::LP_CTRL_WMASK;
			else if (wr_ev && addr_reg == csup_pkg::LP_REG_SAFE)
				safe_reg <= wdata_reg;
			else if (wr_ev && addr_reg == csup_pkg::LP_REG_LIMIT)
				limit_reg <= wdata_reg;
			else if (wr_ev && addr_reg == csup_pkg::LP_REG_VREG)
				vreg_reg <= wdata_reg;
			else if (wr_ev && addr_reg == csup_pkg::LP_REG_ICHG)
				ichg_reg <= wdata_reg;
			if (safe_exp)
			begin
				ctrl_reg[csup_pkg::LP_CTRL_INH] <= 1'b1;
				vreg_reg <= csup_pkg::LP_VREG_DEF;
				ichg_reg <= csup_pkg::LP_ICHG_DEF;
			end
		end

	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			o_default_mode <= 1'b0;
			host_seen      <= 1'b0;
			supnew_reg     <= 1'b0;
			safe_flt       <= 1'b0;
		end
		else
		begin
			if (enter_def)
			begin
				o_default_mode <= 1'b1;
				host_seen      <= host_seen && !wd_exp;
			end
			else if (wr_ev)
			begin
				o_default_mode <= 1'b0;
				host_seen      <= 1'b1;
			end
			if (acc_ev && rw_reg && addr_reg == csup_pkg::LP_REG_STATUS)
				supnew_reg <= 1'b0;
			if (new_sup)
				supnew_reg <= 1'b1;
			if (wr_ctrl && !wdata_reg[csup_pkg::LP_CTRL_INH])
				safe_flt <= 1'b0;
			if (safe_exp)
				safe_flt <= 1'b1;
		end

	// ----------------------------------------------------------------
	// Charge and detection sequence
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			state      <= csup_pkg::S_OFF;
			st_cnt     <= 32'h0000_0000;
			absent_reg <= 1'b0;
			done_reg   <= 1'b0;
			start_ev   <= 1'b0;
		end
		else
		begin
			start_ev <= 1'b0;
			if (ms_tick)
				st_cnt <= st_cnt + 32'h0000_0001;
			if (!sup_s || hz_eff)
				state <= csup_pkg::S_OFF;
			else
				case (state)
				csup_pkg::S_OFF:
				begin
					state    <= csup_pkg::S_START;
					st_cnt   <= 32'h0000_0000;
					done_reg <= 1'b0;
				end
				csup_pkg::S_START:
					if (!inhibit && st_cnt >= 32'(P_START_MS))
					begin
						state    <= csup_pkg::S_CHARGE;
						start_ev <= 1'b1;
					end
				csup_pkg::S_CHARGE:
					if (inhibit || safe_exp)
						state <= csup_pkg::S_START;
					else if (term_s && term_en)
					begin
						state  <= csup_pkg::S_SINK;
						st_cnt <= 32'h0000_0000;
					end
				csup_pkg::S_SINK, csup_pkg::S_SOURCE:
					if (inhibit || !term_en)
						state <= inhibit ? csup_pkg::S_START : csup_pkg::S_CHARGE;
					else if (state == csup_pkg::S_SINK && !above_s)
					begin
						absent_reg <= 1'b1;
						state      <= csup_pkg::S_SOURCE;
						st_cnt     <= 32'h0000_0000;
					end
					else if (st_cnt >= 32'(P_DETECT_MS))
					begin
						st_cnt <= 32'h0000_0000;
						if (state == csup_pkg::S_SOURCE)
							state <= csup_pkg::S_SINK;
						else if (absent_reg)
						begin
							absent_reg <= 1'b0;
							state      <= csup_pkg::S_CHARGE;
							start_ev   <= 1'b1;
						end
						else
						begin
							done_reg <= 1'b1;
							state    <= csup_pkg::S_DONE;
						end
					end
				default:
					// Default-mode entry alone never leaves this state
					if (inhibit)
						state <= csup_pkg::S_START;
				endcase
		end

	// ----------------------------------------------------------------
	// Safety timer, watchdog, pulse, outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
		if (i_rst || safe_rst)
		begin
			safe_cnt <= 32'h0000_0000;
			half_reg <= 1'b0;
			safe_exp <= 1'b0;
		end
		else
		begin
			safe_exp <= 1'b0;
			// Reset on entering thermal shutdown and held at zero there; halted when duration is off
			if (state == csup_pkg::S_CHARGE && !therm_s && dur != csup_pkg::LP_DUR_OFF && ms_tick)
			begin
				half_reg <= !half_reg;
				if (!slow_now || half_reg)
				begin
					safe_exp <= safe_cnt >= safe_lim - 32'h0000_0001;
					safe_cnt <= (safe_cnt >= safe_lim - 32'h0000_0001) ? 32'h0000_0000
						: safe_cnt + 32'h0000_0001;
				end
			end
		end

	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			wd_run <= 1'b0;
			wd_cnt <= 32'h0000_0000;
			wd_exp <= 1'b0;
		end
		else
		begin
			wd_exp <= 1'b0;
			if ((acc_ev && !wd_run) || kick_ev)
			begin
				wd_run <= 1'b1;
				wd_cnt <= 32'h0000_0000;
			end
			else if (wd_run && ms_tick)
			begin
				wd_exp <= wd_cnt == 32'(P_WDOG_MS - 1);
				wd_run <= wd_cnt != 32'(P_WDOG_MS - 1);
				wd_cnt <= wd_cnt + 32'h0000_0001;
			end
		end

	assign stat_cnt_end = p_cnt == 8'(csup_pkg::LP_PULSE_US - 1);

	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			o_stat_pulse <= 1'b0;
			p_cnt        <= 8'h00;
		end
		else if (new_sup || safe_exp)
		begin
			o_stat_pulse <= 1'b1;
			p_cnt        <= 8'h00;
		end
		else if (o_stat_pulse && us_tick)
		begin
			o_stat_pulse <= !stat_cnt_end;
			p_cnt        <= p_cnt + 8'h01;
		end

	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			o_discharge_gate_drive <= 1'b1;
			o_detect_sink          <= 1'b0;
			o_detect_source        <= 1'b0;
			o_battery_switch_on    <= 1'b0;
		end
		else
		begin
			o_discharge_gate_drive <= !sup_s | ctrl_reg[csup_pkg::LP_CTRL_HIZ] | cd_s;
			o_detect_sink          <= state == csup_pkg::S_SINK;
			o_detect_source        <= state == csup_pkg::S_SOURCE && !above_s;
			o_battery_switch_on    <= state == csup_pkg::S_CHARGE && !inhibit;
		end
endmodule : csup_device

/* design/csup_pkg.sv */
// Purpose: Shared constants and types for the charge supervisor link
// Assumes: 100 MHz system clock on both ends
// Notes:   Times keep their own unit; counts derive from them
package csup_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int LP_CLK_HZ      = 100_000_000;
	localparam int LP_US_CYC      = LP_CLK_HZ / 1_000_000;
	localparam int LP_US_PER_MS   = 1000;
	localparam int LP_PULSE_US    = 128;
	localparam int LP_START_MS    = 64;
	localparam int LP_DETECT_MS   = 250;
	localparam int LP_WDOG_S      = 30;
	localparam int LP_WDOG_MS     = LP_WDOG_S * 1000;
	localparam int LP_SAFE_MIN    = 27;
	localparam int LP_SAFE_MS     = LP_SAFE_MIN * 60_000;
	localparam int LP_LINK_NS     = 1000;
	localparam int LP_QUARTER_CYC = LP_LINK_NS / 4 / (1_000_000_000 / LP_CLK_HZ);
	// ----------------------------------------------------------------
	// Link frame: read flag, 7-bit address, 8 data bits
	// ----------------------------------------------------------------
	localparam logic [4:0] LP_HDR_LAST   = 5'h07;
	localparam logic [4:0] LP_DATA_FIRST = 5'h08;
	localparam logic [4:0] LP_FRAME_LAST = 5'h0f;
	localparam logic [4:0] LP_FRAME_BITS = 5'h10;
	// ----------------------------------------------------------------
	// Device registers
	// ----------------------------------------------------------------
	localparam logic [6:0] LP_REG_STATUS = 7'h00;
	localparam logic [6:0] LP_REG_LIMIT  = 7'h01;
	localparam logic [6:0] LP_REG_CTRL   = 7'h02;
	localparam logic [6:0] LP_REG_VREG   = 7'h03;
	localparam logic [6:0] LP_REG_ICHG   = 7'h04;
	localparam logic [6:0] LP_REG_SAFE   = 7'h05;
	localparam int         LP_CTRL_KICK  = 7;
	localparam int         LP_CTRL_TERM  = 3;
	localparam int         LP_CTRL_INH   = 1;
	localparam int         LP_CTRL_HIZ   = 0;
	localparam logic [7:0] LP_CTRL_WMASK = 8'h7f;
	localparam int         LP_SAFE_SLOW  = 0;
	localparam int         LP_SAFE_DUR   = 1;
	localparam int         LP_SAFE_LOW   = 3;
	localparam logic [1:0] LP_DUR_OFF    = 2'h3;
	localparam logic [7:0] LP_CTRL_DEF   = 8'h08;
	localparam logic [7:0] LP_VREG_DEF   = 8'h05;
	localparam logic [7:0] LP_ICHG_DEF   = 8'h06;
	localparam logic [7:0] LP_LIMIT_DEF  = 8'h0f;
	localparam logic [7:0] LP_SAFE_DEF   = 8'h00;
	// ----------------------------------------------------------------
	// Host command registers (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] LP_AV_CMD  = 4'h0;
	localparam logic [3:0] LP_AV_STAT = 4'h4;
	localparam int         LP_CMD_RD  = 15;

	typedef enum logic [2:0] {S_OFF, S_START, S_CHARGE, S_SINK, S_SOURCE, S_DONE} csup_state_e;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} csup_hstate_e;
endpackage : csup_pkg

/* design/csup_link_if.sv */
// Purpose: Two-wire link between host and charge supervisor
// Assumes: Data line is open drain with a pull-up
// Notes:   Enables are active low; a driver only pulls low
`timescale 1ns/100ps
interface csup_link_if;
	logic scl;
	logic sda_h_out;
	logic sda_h_oe_n;
	logic sda_d_out;
	logic sda_d_oe_n;
	logic sda;

	assign sda = (sda_h_oe_n | sda_h_out) & (sda_d_oe_n | sda_d_out);

	modport host (output scl, output sda_h_out, output sda_h_oe_n, input sda);
	modport device (input scl, input sda, output sda_d_out, output sda_d_oe_n);
endinterface : csup_link_if

/* design/csup_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Inputs are slow levels, not single-cycle pulses
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module csup_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_ff @(posedge i_clk)
			begin
				meta_reg[g] <= i_d[g];
				o_q[g]      <= meta_reg[g];
			end
		end
	endgenerate
endmodule : csup_sync

/* design/csup_host.sv */
// Purpose: Host end: Avalon-MM command port driving link frames
// Assumes: One frame at a time; software polls busy
// Notes:   Link clock comes from a divider of i_clk
`timescale 1ns/100ps
module csup_host #(
	parameter int P_QUARTER = csup_pkg::LP_QUARTER_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [3:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	csup_link_if.host        link
);
	logic                  sda_s;
	logic                  go_reg;
	logic                  busy_reg;
	logic [15:0]           cmd_reg;
	logic [7:0]            rx_reg;
	logic [15:0]           q_cnt;
	logic                  q_tick;
	logic [1:0]            phase;
	logic [4:0]            bit_idx;
	logic                  scl_reg;
	logic                  oe_n_reg;
	csup_pkg::csup_hstate_e hstate;

	csup_sync #(.W(1)) u_sync (.i_clk(i_clk), .i_d(link.sda), .o_q(sda_s));

	assign link.scl        = scl_reg;
	assign link.sda_h_oe_n = oe_n_reg;
	assign link.sda_h_out  = 1'b0;

	// ----------------------------------------------------------------
	// Bus slave: one wait cycle, commit on the released edge
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			o_waitrequest <= 1'b1;
			o_readdata    <= 32'h0000_0000;
			cmd_reg       <= 16'h0000;
			go_reg        <= 1'b0;
		end
		else
		begin
			go_reg <= 1'b0;
			if ((i_read || i_write) && o_waitrequest)
			begin
				o_waitrequest <= 1'b0;
				if (i_address == csup_pkg::LP_AV_STAT)
					o_readdata <= {16'h0000, rx_reg, 7'h00, busy_reg};
				else
					o_readdata <= 32'h0000_0000;
			end
			else
			begin
				o_waitrequest <= 1'b1;
				// Writes while busy are dropped so a frame is never torn
				if (i_write && !o_waitrequest && i_address == csup_pkg::LP_AV_CMD && !busy_reg)
				begin
					cmd_reg <= i_writedata[15:0];
					go_reg  <= 1'b1;
				end
			end
		end

	// ----------------------------------------------------------------
	// Quarter-bit divider
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
		if (i_rst || q_cnt == 16'(P_QUARTER - 1))
		begin
			q_cnt  <= 16'h0000;
			q_tick <= !i_rst;
		end
		else
		begin
			q_cnt  <= q_cnt + 16'h0001;
			q_tick <= 1'b0;
		end

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
		if (i_rst)
		begin
			hstate   <= csup_pkg::H_IDLE;
			busy_reg <= 1'b0;
			phase    <= 2'h0;
			bit_idx  <= 5'h00;
			scl_reg  <= 1'b1;
			oe_n_reg <= 1'b1;
			rx_reg   <= 8'h00;
		end
		else if (hstate == csup_pkg::H_IDLE)
		begin
			phase <= 2'h0;
			if (go_reg)
			begin
				busy_reg <= 1'b1;
				hstate   <= csup_pkg::H_START;
			end
		end
		else if (q_tick)
		begin
			phase <= phase + 2'h1;
			case (hstate)
			csup_pkg::H_START:
				if (phase == 2'h0)
					oe_n_reg <= 1'b0;
				else
				begin
					scl_reg <= 1'b0;
					phase   <= 2'h0;
					bit_idx <= 5'h00;
					hstate  <= csup_pkg::H_BIT;
				end
			csup_pkg::H_BIT:
				case (phase)
				2'h0:
					// Release the line for the data half of a read
					if (cmd_reg[csup_pkg::LP_CMD_RD] && bit_idx >= csup_pkg::LP_DATA_FIRST)
						oe_n_reg <= 1'b1;
					else
						oe_n_reg <= cmd_reg[4'(csup_pkg::LP_FRAME_LAST - bit_idx)];
				2'h1: scl_reg <= 1'b1;
				2'h2:
					if (cmd_reg[csup_pkg::LP_CMD_RD] && bit_idx >= csup_pkg::LP_DATA_FIRST)
						rx_reg <= {rx_reg[6:0], sda_s};
				default:
				begin
					scl_reg <= 1'b0;
					bit_idx <= bit_idx + 5'h01;
					if (bit_idx == csup_pkg::LP_FRAME_LAST)
						hstate <= csup_pkg::H_STOP;
				end
				endcase
			default:
				case (phase)
				2'h0: oe_n_reg <= 1'b0;
				2'h1: scl_reg <= 1'b1;
				2'h2: oe_n_reg <= 1'b1;
				default:
				begin
					busy_reg <= 1'b0;
					hstate   <= csup_pkg::H_IDLE;
				end
				endcase
			endcase
		end
endmodule : csup_host

/* sim/csup_properties.sv */
// Purpose: Device-side timing checks
// Assumes: Bench timing, 1 us = 2 cycles, 1 ms = 8 cycles
// Notes:   Pins take about 3 cycles to reach the outputs
`timescale 1ns/100ps
module csup_properties (
	input	wire logic	i_clk,
	input	wire logic	i_rst,
	input	wire logic	i_supply_valid,
	input	wire logic	i_chip_disable_pin,
	input	wire logic	o_stat_pulse,
	input	wire logic	o_discharge_gate_drive,
	input	wire logic	o_detect_sink,
	input	wire logic	o_detect_source,
	input	wire logic	o_battery_switch_on,
	input	wire logic	i_scl,
	input	wire logic	i_sda_d_oe_n
);
	logic [8:0] pc_reg;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Pulse length, cleared while low
	always_ff @(posedge i_clk)
		pc_reg <= o_stat_pulse ? pc_reg + 9'h001 : 9'h000;
	// ------
	// Checks
	// ------
	a_gate_causes: assert property ((!i_supply_valid || i_chip_disable_pin) [*4]
		|-> o_discharge_gate_drive) else $error("gate off");
	a_pulse_len: assert property ($fell(o_stat_pulse)
		|-> pc_reg inside {[9'h0fe:9'h100]}) else $error("pulse length");
	a_pulse_single: assert property ($fell(o_stat_pulse) |-> !o_stat_pulse [*8])
		else $error("pulse repeated");
	a_detect_excl: assert property (!(o_detect_sink && o_detect_source))
		else $error("sink with source");
	a_sink_bound: assert property ($rose(o_detect_sink) |-> ##[1:40] !o_detect_sink)
		else $error("sink too long");
	a_source_bound: assert property ($rose(o_detect_source) |-> ##[1:40] !o_detect_source)
		else $error("source too long");
	a_sink_switch: assert property (o_detect_sink |-> !o_battery_switch_on)
		else $error("switch on in sink");
	a_source_switch: assert property (o_detect_source |-> !o_battery_switch_on)
		else $error("switch on in source");
	a_sda_pull_low: assert property ($fell(i_sda_d_oe_n) |-> !i_scl)
		else $error("data pulled with clock high");
endmodule : csup_properties

/* sim/csup_tb_top.sv */
// Purpose: Bench joining host and device ends
// Assumes: 1 ms = 8 cycles; one frame takes about 1800 cycles
// Notes:   Watchdog set longer than a frame, else frames trip it
`timescale 1ns/100ps
module csup_tb_top;
	logic		i_clk, i_rst, rd, wr, sup, cd, va, tm, wq;
	logic		pl, gt, sk, sr, sw, dm;
	logic		vl, ct, th, ba, fa;
	logic [3:0]	ad;
	logic [31:0]	wd, rq, q;
	logic [7:0]	vr, ic, il;
	int		fails, comparisons, cyc;
	wire [5:0]	ob = {pl, gt, sk, sr, sw, dm};
	csup_link_if link ();
	csup_host csup_host_i (.i_clk(i_clk), .i_rst(i_rst), .i_address(ad), .i_read(rd),
		.i_write(wr), .i_writedata(wd), .o_readdata(rq), .o_waitrequest(wq), .link(link));
	csup_device #(.P_US_CYC(2), .P_US_PER_MS(4), .P_DETECT_MS(3), .P_WDOG_MS(400),
		.P_SAFE_MS(10)) csup_device_i (.i_clk(i_clk), .i_rst(i_rst), .link(link),
		.i_supply_valid(sup), .i_chip_disable_pin(cd), .i_vbat_above_detect(va),
		.i_vbat_low(vl), .i_curtail(ct), .i_thermal_shutdown(th),
		.i_battery_attached(ba), .i_fault_active(fa), .i_term_met(tm),
		.o_stat_pulse(pl), .o_discharge_gate_drive(gt), .o_detect_sink(sk),
		.o_detect_source(sr), .o_battery_switch_on(sw), .o_default_mode(dm),
		.o_battery_regulation_level(vr), .o_charge_current_setting(ic), .o_input_limit(il));
	csup_properties csup_properties_i (.i_clk(i_clk), .i_rst(i_rst), .i_supply_valid(sup),
		.i_chip_disable_pin(cd), .o_stat_pulse(pl), .o_discharge_gate_drive(gt),
		.o_detect_sink(sk), .o_detect_source(sr), .o_battery_switch_on(sw),
		.i_scl(link.scl), .i_sda_d_oe_n(link.sda_d_oe_n));
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
		if (++cyc == 30000)
		begin
			fails++;
			end_of_test();
		end
	task automatic end_of_test();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Bounded wait on one output bit, then compare
	task automatic wc(input int b, input logic v, input int n);
		for (int k = 0; k < n && ob[b] !== v; k++)
			@(posedge i_clk);
		chk({7'h00, ob[b]}, {7'h00, v});
	endtask : wc
	task automatic av(input logic w, input logic [3:0] a, input logic [15:0] d);
		wr <= w;
		rd <= !w;
		ad <= a;
		wd <= {16'h0000, d};
		do
			@(posedge i_clk);
		while (wq !== 1'b0);
		q = rq;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge i_clk);
	endtask : av
	// One frame; busy polled, so no fixed frame time assumed
	task automatic lk(input logic [15:0] c);
		av(1'b1, 4'h0, c);
		do
			av(1'b0, 4'h4, 16'h0000);
		while (q[0] !== 1'b0);
	endtask : lk
	// ---------
	// Scenarios
	// ---------
	task automatic t_sup();
		wc(4, 1'b1, 0);
		vl <= 1'b1;
		wc(0, 1'b1, 9);
		vl <= 1'b0;
		sup <= 1'b1;
		wc(5, 1'b1, 20);
		repeat (400) @(posedge i_clk);
		wc(1, 1'b0, 0);
		wc(4, 1'b0, 0);
		wc(1, 1'b1, 200);
		wc(1, 1'b0, 150);
		wc(5, 1'b1, 20);
	endtask : t_sup
	task automatic t_det();
		// Safety timer off and a kick, so neither trips mid-detection
		lk(16'h0506);
		lk(16'h0288);
		wc(1, 1'b1, 600);
		tm <= 1'b1;
		wc(3, 1'b1, 20);
		wc(3, 1'b0, 20);
		wc(2, 1'b1, 20);
		va <= 1'b1;
		wc(2, 1'b0, 20);
		wc(3, 1'b1, 60);
		repeat (12) @(posedge i_clk);
		wc(3, 1'b1, 0);
		wc(1, 1'b1, 40);
		wc(3, 1'b1, 20);
		wc(3, 1'b0, 60);
		tm <= 1'b0;
		lk(16'h8000);
		chk(q[15:8] & 8'h06, 8'h02);
	endtask : t_det
	task automatic t_wd();
		lk(16'h0506);
		lk(16'h0208);
		lk(16'h0320);
		chk(vr, 8'h20);
		wc(0, 1'b0, 0);
		wc(0, 1'b1, 4000);
		chk(vr, csup_pkg::LP_VREG_DEF);
		chk(ic, csup_pkg::LP_ICHG_DEF);
		chk(il, csup_pkg::LP_LIMIT_DEF);
		cd <= 1'b1;
		wc(4, 1'b1, 9);
		cd <= 1'b0;
		wc(4, 1'b0, 9);
		lk(16'h0209);
		wc(0, 1'b0, 0);
		wc(4, 1'b1, 0);
	endtask : t_wd
	initial
	begin
		{rd, wr, sup, cd, va, tm, vl, ct, th, fa, ad, wd} = '0;
		ba = 1'b1;
		i_rst = 1'b1;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_sup();
		t_det();
		t_wd();
		end_of_test();
	end
endmodule : csup_tb_top
